// ==== rtl/tcc_defines.vh ====
// constants for the three-channel 16-bit timer/counter block
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

`define TCC_NUM_CH 3
// per-channel word offsets, channel base is index times 0x40
`define TCC_CCR_OFF 6'h00
`define TCC_CMR_OFF 6'h04
`define TCC_CV_OFF 6'h10
`define TCC_RA_OFF 6'h14
`define TCC_RB_OFF 6'h18
`define TCC_RC_OFF 6'h1C
`define TCC_SR_OFF 6'h20
`define TCC_BCR_ADDR 8'hC0
`define TCC_BMR_ADDR 8'hC4
// channel control bits
`define TCC_CLOCK_ENABLE_CMD_BIT 0
`define TCC_CLOCK_DISABLE_CMD_BIT 1
`define TCC_SOFT_TRIGGER_CMD_BIT 2
`define TCC_SYNC_BIT 0
// channel mode fields
`define TCC_CLKS_RNG 2:0
`define TCC_CLOCK_INVERT_BIT_BIT 3
`define TCC_BURST_RNG 5:4
`define TCC_STOP_BIT 6
`define TCC_DIS_BIT 7
`define TCC_ETRG_RNG 9:8
`define TCC_EXT_TRIGGER_LINE_SELECT_BIT 10
`define TCC_EEVT_RNG 12:11
`define TCC_EXT_EVENT_TRIGGER_ENABLE_BIT 13
`define TCC_RC_COMPARE_TRIGGER_ENABLE_BIT 14
`define TCC_WAVE_BIT 15
`define TCC_RA_LOAD_EDGE_RNG 17:16
`define TCC_RB_LOAD_EDGE_RNG 19:18
`define TCC_CMR_W 20
`define TCC_CMR_RST 20'h00000
// status bits
`define TCC_COVF_BIT 0
`define TCC_LOVR_BIT 1
`define TCC_CLOCK_RUNNING_FLAG_BIT 16
// prescaler taps giving /2, /8, /32, /128 and the slow clock stand-in /1024
`define TCC_PRE_W 10
`define TCC_TAP1 0
`define TCC_TAP2 2
`define TCC_TAP3 4
`define TCC_TAP4 6
`define TCC_TAP5 9
`define TCC_CNT_MAX 16'hFFFF

`endif

// ==== rtl/tcc_prescale.v ====
// free-running prescaler producing the five internal divided clock levels
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_prescale (
  input wire core_clk_in,
  input wire arst_n_in,
  output wire [4:0] div_clk_out
);
  reg [`TCC_PRE_W-1:0] pre_ff;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_ff <= {`TCC_PRE_W{1'b0}};
    end else begin
      pre_ff <= pre_ff + {{(`TCC_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // levels, not pulses: each channel finds its own edge after inversion
  assign div_clk_out = {pre_ff[`TCC_TAP5], pre_ff[`TCC_TAP4], pre_ff[`TCC_TAP3],
                        pre_ff[`TCC_TAP2], pre_ff[`TCC_TAP1]};
endmodule

// ==== rtl/tcc_edge.v ====
// edge finder for a channel's clock, line and external clock levels
`timescale 1ns/1ps
module tcc_edge (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [5:0] lvl_in,
  output wire [5:0] rise_out,
  output wire [5:0] fall_out
);
  reg [5:0] prev_ff;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_ff <= 6'h00;
    end else begin
      prev_ff <= lvl_in;
    end
  end

  assign rise_out = lvl_in & ~prev_ff;
  assign fall_out = ~lvl_in & prev_ff;
endmodule

// ==== rtl/tcc_top.v ====
// three-channel 16-bit timer/counter with capture, triggers and clock control
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_top (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [2:0] ext_clock_pin_in,
  input wire [2:0] io_line_a_in,
  input wire [2:0] io_line_b_in,
  output reg [31:0] reg_rdata_out,
  output reg [2:0] io_line_a_out,
  output reg [2:0] io_line_a_oe_n_out,
  output reg [2:0] io_line_b_out,
  output reg [2:0] io_line_b_oe_n_out
);
  function reg_at;
    input [7:0] addr;
    input [1:0] ch;
    input [5:0] off;
    begin
      reg_at = (addr[7:6] == ch) && (addr[5:0] == off);
    end
  endfunction

  // 0 none, 1 rising, 2 falling, 3 both
  function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      edge_hit = ((sel == 2'h1) && rise) || ((sel == 2'h2) && fall) ||
                 ((sel == 2'h3) && (rise || fall));
    end
  endfunction

  // 0 own pin, 1 none, 2 and 3 the other channels' line a
  function xc_route;
    input [1:0] sel;
    input pin;
    input chain_lo;
    input chain_hi;
    begin
      case (sel)
        2'h0: xc_route = pin;
        2'h2: xc_route = chain_lo;
        2'h3: xc_route = chain_hi;
        default: xc_route = 1'b0;
      endcase
    end
  endfunction

  wire [4:0] int_clk;
  wire [2:0] wave_w;
  wire [2:0] b_in_w;
  wire [95:0] rd_bus;
  reg [5:0] block_mode_ff;
  reg [2:0] xc;
  wire [2:0] io_a_eff;
  wire sync_pulse;

  tcc_prescale u_prescale (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .div_clk_out(int_clk)
  );

  // a channel in waveform mode chains its own driven level, else the pin
  assign io_a_eff = (wave_w & io_line_a_out) | (~wave_w & io_line_a_in);

  always @* begin
    xc[0] = xc_route(block_mode_ff[1:0], ext_clock_pin_in[0], io_a_eff[1], io_a_eff[2]);
    xc[1] = xc_route(block_mode_ff[3:2], ext_clock_pin_in[1], io_a_eff[0], io_a_eff[2]);
    xc[2] = xc_route(block_mode_ff[5:4], ext_clock_pin_in[2], io_a_eff[0], io_a_eff[1]);
  end

  assign sync_pulse = reg_wr_in && (reg_addr_in == `TCC_BCR_ADDR) &&
                      reg_wdata_in[`TCC_SYNC_BIT];

  genvar g;
  generate
    for (g = 0; g < `TCC_NUM_CH; g = g + 1) begin : g_ch
      localparam integer CH_IDX = g;
      localparam [1:0] CH = CH_IDX[1:0];
      reg [`TCC_CMR_W-1:0] mode_ff;
      reg [15:0] cnt_ff;
      reg [15:0] ra_ff;
      reg [15:0] rb_ff;
      reg [15:0] rc_ff;
      reg ovf_ff;
      reg lovr_ff;
      reg clk_en_ff;
      reg run_ff;
      reg pend_ff;
      reg a_done_ff;
      reg ra_unread_ff;
      reg rb_unread_ff;
      reg src_lvl;
      reg burst_ok;
      reg [31:0] ch_rd;
      wire [5:0] rise_w;
      wire [5:0] fall_w;
      wire wave = mode_ff[`TCC_WAVE_BIT];
      wire [2:0] clks = mode_ff[`TCC_CLKS_RNG];
      wire [1:0] burst = mode_ff[`TCC_BURST_RNG];
      wire [1:0] eevt = mode_ff[`TCC_EEVT_RNG];
      wire wr_ccr = reg_wr_in && reg_at(reg_addr_in, CH, `TCC_CCR_OFF);
      wire wr_cmr = reg_wr_in && reg_at(reg_addr_in, CH, `TCC_CMR_OFF);
      wire wr_ra = reg_wr_in && wave && reg_at(reg_addr_in, CH, `TCC_RA_OFF);
      wire wr_rb = reg_wr_in && wave && reg_at(reg_addr_in, CH, `TCC_RB_OFF);
      wire wr_rc = reg_wr_in && reg_at(reg_addr_in, CH, `TCC_RC_OFF);
      wire rd_ra = reg_rd_in && reg_at(reg_addr_in, CH, `TCC_RA_OFF);
      wire rd_rb = reg_rd_in && reg_at(reg_addr_in, CH, `TCC_RB_OFF);
      wire rd_sr = reg_rd_in && reg_at(reg_addr_in, CH, `TCC_SR_OFF);
      wire en_cmd = wr_ccr && reg_wdata_in[`TCC_CLOCK_ENABLE_CMD_BIT];
      wire sw_trig = wr_ccr && reg_wdata_in[`TCC_SOFT_TRIGGER_CMD_BIT];
      wire [2:0] ev_idx;
      wire ext_trig;
      wire tick;
      wire [15:0] nxt_cnt;
      wire rc_ev;
      wire trig;
      wire ld_a;
      wire ld_b;
      wire stop_ev;
      wire dis_ev;

      always @* begin
        case (clks)
          3'h5: src_lvl = xc[0];
          3'h6: src_lvl = xc[1];
          3'h7: src_lvl = xc[2];
          default: src_lvl = int_clk[clks];
        endcase
      end

      always @* begin
        if (burst == 2'h0) begin
          burst_ok = 1'b1;
        end else begin
          burst_ok = xc[burst - 2'h1];
        end
      end

      // bit 0 is the counting clock, inverted when the invert bit is set, before its edge is found
      tcc_edge u_edge (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .lvl_in({xc, io_line_b_in[g], io_a_eff[g], src_lvl ^ mode_ff[`TCC_CLOCK_INVERT_BIT_BIT]}),
        .rise_out(rise_w),
        .fall_out(fall_w)
      );

      // event source 0 is line b, 1 to 3 the external clocks
      assign ev_idx = (eevt == 2'h0) ? 3'h2 : {1'b0, eevt} + 3'h2;
      assign ext_trig = wave ?
        (mode_ff[`TCC_EXT_EVENT_TRIGGER_ENABLE_BIT] &&
         edge_hit(mode_ff[`TCC_ETRG_RNG], rise_w[ev_idx], fall_w[ev_idx])) :
        (mode_ff[`TCC_EXT_TRIGGER_LINE_SELECT_BIT] ?
         edge_hit(mode_ff[`TCC_ETRG_RNG], rise_w[1], fall_w[1]) :
         edge_hit(mode_ff[`TCC_ETRG_RNG], rise_w[2], fall_w[2]));

      assign tick = rise_w[0] && clk_en_ff && run_ff && burst_ok;
      // a pending trigger takes effect on the next active edge only
      assign nxt_cnt = pend_ff ? 16'h0000 : cnt_ff + 16'h0001;
      assign rc_ev = tick && (nxt_cnt == rc_ff);
      assign trig = sw_trig || sync_pulse || ext_trig ||
                    (rc_ev && mode_ff[`TCC_RC_COMPARE_TRIGGER_ENABLE_BIT]);
      assign ld_a = !wave && !a_done_ff &&
                    edge_hit(mode_ff[`TCC_RA_LOAD_EDGE_RNG], rise_w[1], fall_w[1]);
      assign ld_b = !wave && a_done_ff &&
                    edge_hit(mode_ff[`TCC_RB_LOAD_EDGE_RNG], rise_w[1], fall_w[1]);
      assign stop_ev = mode_ff[`TCC_STOP_BIT] && (ld_b || (wave && rc_ev));
      assign dis_ev = (wr_ccr && reg_wdata_in[`TCC_CLOCK_DISABLE_CMD_BIT]) ||
                      (mode_ff[`TCC_DIS_BIT] && (ld_b || (wave && rc_ev)));

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          mode_ff <= `TCC_CMR_RST;
          rc_ff <= 16'h0000;
        end else begin
          if (wr_cmr) begin
            mode_ff <= reg_wdata_in[`TCC_CMR_W-1:0];
          end
          if (wr_rc) begin
            rc_ff <= reg_wdata_in[15:0];
          end
        end
      end

      // clock enable and start/stop; disable wins over a same-cycle enable
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          clk_en_ff <= 1'b0;
          run_ff <= 1'b0;
          pend_ff <= 1'b0;
        end else begin
          if (dis_ev) begin
            clk_en_ff <= 1'b0;
          end else if (en_cmd) begin
            clk_en_ff <= 1'b1;
          end
          if (dis_ev) begin
            run_ff <= 1'b0;
          end else if (clk_en_ff) begin
            if (trig) begin
              run_ff <= 1'b1;
            end else if (stop_ev) begin
              run_ff <= 1'b0;
            end
          end
          if (clk_en_ff && trig) begin
            pend_ff <= 1'b1;
          end else if (tick) begin
            pend_ff <= 1'b0;
          end
        end
      end

      // counter holds whenever no qualified edge arrives
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          cnt_ff <= 16'h0000;
          ovf_ff <= 1'b0;
        end else begin
          if (tick) begin
            cnt_ff <= nxt_cnt;
          end
          ovf_ff <= (ovf_ff && !rd_sr) ||
                    (tick && !pend_ff && (cnt_ff == `TCC_CNT_MAX));
        end
      end

      // capture sequencing; a fresh load beats a read in the same cycle
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          ra_ff <= 16'h0000;
          rb_ff <= 16'h0000;
          a_done_ff <= 1'b0;
          ra_unread_ff <= 1'b0;
          rb_unread_ff <= 1'b0;
          lovr_ff <= 1'b0;
        end else begin
          if (trig) begin
            a_done_ff <= 1'b0;
          end else if (ld_a) begin
            a_done_ff <= 1'b1;
          end else if (ld_b) begin
            a_done_ff <= 1'b0;
          end
          if (ld_a) begin
            ra_ff <= cnt_ff;
          end else if (wr_ra) begin
            ra_ff <= reg_wdata_in[15:0];
          end
          if (ld_b) begin
            rb_ff <= cnt_ff;
          end else if (wr_rb) begin
            rb_ff <= reg_wdata_in[15:0];
          end
          ra_unread_ff <= ld_a || (ra_unread_ff && !rd_ra);
          rb_unread_ff <= ld_b || (rb_unread_ff && !rd_rb);
          lovr_ff <= (lovr_ff && !rd_sr) || (ld_a && ra_unread_ff) ||
                     (ld_b && rb_unread_ff);
        end
      end

      always @* begin
        ch_rd = 32'h00000000;
        case (reg_addr_in[5:0])
          `TCC_CMR_OFF: ch_rd[`TCC_CMR_W-1:0] = mode_ff;
          `TCC_CV_OFF: ch_rd[15:0] = cnt_ff;
          `TCC_RA_OFF: ch_rd[15:0] = ra_ff;
          `TCC_RB_OFF: ch_rd[15:0] = rb_ff;
          `TCC_RC_OFF: ch_rd[15:0] = rc_ff;
          `TCC_SR_OFF: begin
            ch_rd[`TCC_COVF_BIT] = ovf_ff;
            ch_rd[`TCC_LOVR_BIT] = lovr_ff;
            ch_rd[`TCC_CLOCK_RUNNING_FLAG_BIT] = clk_en_ff;
          end
          default: ch_rd = 32'h00000000;
        endcase
      end

      assign rd_bus[g*32 +: 32] = ch_rd;
      assign wave_w[g] = wave;
      // line b stays an input when it is the waveform event source
      assign b_in_w[g] = !wave || (eevt == 2'h0);
    end
  endgenerate

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      block_mode_ff <= 6'h00;
      reg_rdata_out <= 32'h00000000;
      io_line_a_out <= 3'h0;
      io_line_a_oe_n_out <= 3'h7;
      io_line_b_out <= 3'h0;
      io_line_b_oe_n_out <= 3'h7;
    end else begin
      if (reg_wr_in && (reg_addr_in == `TCC_BMR_ADDR)) begin
        block_mode_ff <= reg_wdata_in[5:0];
      end
      // read data stands for exactly one cycle, zero otherwise
      if (!reg_rd_in) begin
        reg_rdata_out <= 32'h00000000;
      end else if (reg_addr_in[7:6] != 2'h3) begin
        reg_rdata_out <= rd_bus[reg_addr_in[7:6]*32 +: 32];
      end else if (reg_addr_in == `TCC_BMR_ADDR) begin
        reg_rdata_out <= {26'h0, block_mode_ff};
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
      // no waveform drive levels are generated; both line outputs are held low here
      io_line_a_out <= 3'h0;
      io_line_b_out <= 3'h0;
      io_line_a_oe_n_out <= ~wave_w;
      io_line_b_oe_n_out <= b_in_w;
    end
  end
endmodule

// ==== dv/tcc_top_properties.sv ====
// concurrent checks on the timer block's register port and line directions
`timescale 1ns/1ps
module tcc_top_properties (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire [2:0] io_line_a_oe_n_out,
  input wire [2:0] io_line_b_oe_n_out
);
  reg [2:0] wave_ff;
  reg [2:0] evz_ff;
  wire mode_wr = reg_wr_in && reg_addr_in[5:0] == 6'h04 && reg_addr_in[7:6] != 2'b11;
  // shadow of the mode bits that decide line direction, rebuilt from bus writes
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wave_ff <= 3'h0;
      evz_ff <= 3'h7;
    end else if (mode_wr) begin
      wave_ff[reg_addr_in[7:6]] <= reg_wdata_in[15];
      evz_ff[reg_addr_in[7:6]] <= reg_wdata_in[12:11] == 2'b00;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_ctl(d);
    reg_wr_in && reg_addr_in == 8'h00 && reg_wdata_in[2:0] == d;
  endsequence
  sequence s_rd(a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  a_mode_readback: assert property (reg_wr_in && reg_addr_in == 8'h04 ##1 s_rd(8'h04)
    |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 32'h000FFFFF)) else $error("mode readback");
  a_clk_running: assert property (s_ctl(3'h1) ##1 s_rd(8'h20) |=> reg_rdata_out[16])
    else $error("enabled clock not shown");
  a_clk_stopped: assert property (s_ctl(3'h2) ##1 s_rd(8'h20) |=> !reg_rdata_out[16])
    else $error("disabled clock shown running");
  a_dis_holds: assert property (s_ctl(3'h2) ##1 s_rd(8'h10) ##1 s_rd(8'h10)
    |=> reg_rdata_out == $past(reg_rdata_out)) else $error("count moved while disabled");
  a_trig_ignored: assert property (s_ctl(3'h2) ##1 s_ctl(3'h4) ##1 s_rd(8'h10) [*2]
    |=> $stable(reg_rdata_out)) else $error("trigger acted while disabled");
  a_cnt_width: assert property (s_rd(8'h10) |=> reg_rdata_out[31:16] == 16'h0000)
    else $error("count wider than 16 bits");
  genvar g;
  for (g = 0; g < 3; g = g + 1) begin : g_ch
    a_capture_dir: assert property (!wave_ff[g] && !$past(wave_ff[g]) |->
      io_line_a_oe_n_out[g] && io_line_b_oe_n_out[g]) else $error("line driven in capture");
    a_wave_dir: assert property (wave_ff[g] && $past(wave_ff[g]) && $stable(evz_ff[g]) |->
      !io_line_a_oe_n_out[g] && io_line_b_oe_n_out[g] == evz_ff[g]) else $error("wave dir");
  end
endmodule

bind tcc_top tcc_top_properties i_tcc_top_properties (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .io_line_a_oe_n_out(io_line_a_oe_n_out),
  .io_line_b_oe_n_out(io_line_b_oe_n_out)
);

// ==== dv/tcc_far_model.sv ====
// far-side sources: external clock pins and line a of each channel
`timescale 1ns/1ps
module tcc_far_model (
  input wire core_clk_in,
  input wire [2:0] pin_req_in,
  input wire [2:0] a_req_in,
  output reg [2:0] ext_clock_pin_out = 3'h0,
  output reg [2:0] io_line_a_out = 3'h0
);
  // levels move only on request, so pins stand still between bursts and each
  // level lasts several core cycles, well above the detectable minimum
  always @(posedge core_clk_in) begin
    ext_clock_pin_out <= pin_req_in;
    io_line_a_out <= a_req_in;
  end
endmodule

// ==== dv/test_tcc_top.sv ====
// self-checking bench for the timer: bus traffic, clock pins and capture line
`timescale 1ns/1ps
module test_tcc_top;
  reg core_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg [7:0] reg_addr_in = 8'h00;
  reg [31:0] reg_wdata_in = 32'h0;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg [2:0] pin_req = 3'h0;
  reg [2:0] a_req = 3'h0;
  wire [2:0] ext_pin, a_far, a_drv, a_oe_n, b_drv, b_oe_n;
  wire [31:0] rdata;
  // the far side drives a line only while the block has released it
  wire [2:0] a_wire = (a_oe_n & a_far) | (~a_oe_n & a_drv);
  wire [2:0] b_wire = ~b_oe_n & b_drv;
  integer n_fail = 0, checked = 0, seed = 32'hE3B128F9, t = 0, i;
  integer m_cv = 0, m_en = 0, m_run = 0, m_pend = 0, m_gate = 1;
  // rc trigger model and the level that tick toggles as counting clock
  integer m_rc = 0, m_rct = 0, m_src = 0;
  integer m_mode [0:2];
  integer cap_q [$];
  tcc_top i_tcc_top (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .ext_clock_pin_in(ext_pin), .io_line_a_in(a_wire), .io_line_b_in(b_wire),
    .reg_rdata_out(rdata), .io_line_a_out(a_drv), .io_line_a_oe_n_out(a_oe_n),
    .io_line_b_out(b_drv), .io_line_b_oe_n_out(b_oe_n)
  );
  tcc_far_model i_tcc_far_model (
    .core_clk_in(core_clk_in), .pin_req_in(pin_req), .a_req_in(a_req),
    .ext_clock_pin_out(ext_pin), .io_line_a_out(a_far)
  );
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task op(input w, input r, input [7:0] a, input [31:0] d);
    begin
      reg_wr_in <= w;
      reg_rd_in <= r;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
    end
  endtask
  // read data is checked mid-cycle so the next request can follow back to back
  task automatic rd(input [7:0] a, input [31:0] e);
    begin
      op(1'b0, 1'b1, a, 32'h0);
      fork
        begin
          @(negedge core_clk_in);
          chk(rdata, e);
        end
      join_none
    end
  endtask
  task idle(input integer n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task ctl(input [2:0] d);
    begin
      op(1'b1, 1'b0, 8'h00, {29'h0, d});
      if (d[1]) begin
        m_en = 0;
        m_run = 0;
      end else if (d[0]) begin
        m_en = 1;
      end else if (m_en) begin
        m_run = 1;
        m_pend = 1;
      end
    end
  endtask
  task set_lvl(input integer which, input v);
    begin
      if (which == 0) pin_req[0] <= v;
      else if (which == 1) pin_req[1] <= v;
      else if (which == 2) a_req[0] <= v;
      else a_req[1] <= v;
      idle(5);
    end
  endtask
  task tick(input integer n);
    repeat (n) begin
      set_lvl(m_src, 1'b1);
      set_lvl(m_src, 1'b0);
      if (m_en && m_run && m_gate) begin
        m_cv = m_pend ? 0 : (m_cv + 1) % 65536;
        m_pend = 0;
        if (m_rct && m_cv == m_rc) m_pend = 1;
      end
    end
  endtask
  task done;
    begin
      t = t + 1;
      $display("test %0d done", t);
    end
  endtask
  task conclude;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    idle(1);
    for (i = 0; i < 3; i = i + 1) begin
      rd({i[1:0], 6'h04}, 32'h0);
      rd({i[1:0], 6'h10}, 32'h0);
      rd({i[1:0], 6'h20}, 32'h0);
    end
    rd(8'hC4, 32'h0);
    rd(8'h08, 32'h0);
    done;
    for (i = 0; i < 3; i = i + 1) begin
      m_mode[i] = $random(seed) & 32'h000F7FFF;
      op(1'b1, 1'b0, {i[1:0], 6'h04}, m_mode[i]);
      rd({i[1:0], 6'h04}, m_mode[i]);
    end
    for (i = 0; i < 3; i = i + 1) rd({i[1:0], 6'h04}, m_mode[i]);
    op(1'b1, 1'b0, 8'h44, 32'h8000);
    op(1'b1, 1'b0, 8'h84, 32'h8800);
    idle(3);
    chk({29'h0, a_oe_n}, 32'h1);
    chk({29'h0, b_oe_n}, 32'h3);
    chk({26'h0, a_drv, b_drv}, 32'h0);
    done;
    op(1'b1, 1'b0, 8'hC4, 32'h0);
    op(1'b1, 1'b0, 8'h04, 32'h5);
    ctl(3'h1);
    rd(8'h20, 32'h10000);
    ctl(3'h4);
    tick(5);
    rd(8'h10, m_cv);
    ctl(3'h4);
    rd(8'h10, m_cv);
    tick(1);
    rd(8'h10, m_cv);
    op(1'b1, 1'b0, 8'hC0, 32'h1);
    m_pend = 1;
    tick(2);
    rd(8'h10, m_cv);
    done;
    ctl(3'h2);
    rd(8'h20, 32'h0);
    ctl(3'h2);
    rd(8'h10, m_cv);
    rd(8'h10, m_cv);
    ctl(3'h2);
    ctl(3'h4);
    rd(8'h10, m_cv);
    rd(8'h10, m_cv);
    tick(3);
    rd(8'h10, m_cv);
    ctl(3'h1);
    tick(2);
    rd(8'h10, m_cv);
    ctl(3'h4);
    tick(3);
    rd(8'h10, m_cv);
    done;
    // invert is switched only at levels where the flip of the level gives a falling edge, which does not count
    set_lvl(0, 1'b1);
    op(1'b1, 1'b0, 8'h04, 32'hD);
    set_lvl(0, 1'b0);
    m_cv = m_cv + 2;
    rd(8'h10, m_cv);
    set_lvl(0, 1'b1);
    rd(8'h10, m_cv);
    set_lvl(0, 1'b0);
    m_cv = m_cv + 1;
    op(1'b1, 1'b0, 8'h04, 32'h25);
    m_gate = 0;
    tick(2);
    rd(8'h10, m_cv);
    set_lvl(1, 1'b1);
    m_gate = 1;
    tick(2);
    rd(8'h10, m_cv);
    done;
    op(1'b1, 1'b0, 8'h04, 32'h50045);
    ctl(3'h4);
    tick(2);
    set_lvl(2, 1'b1);
    cap_q.push_back(m_cv);
    set_lvl(2, 1'b0);
    tick(1);
    set_lvl(2, 1'b1);
    cap_q.push_back(m_cv);
    m_run = 0;
    set_lvl(2, 1'b0);
    tick(2);
    set_lvl(2, 1'b1);
    cap_q.push_back(m_cv);
    rd(8'h20, 32'h10002);
    rd(8'h14, cap_q[2]);
    rd(8'h18, cap_q[1]);
    rd(8'h10, m_cv);
    rd(8'h20, 32'h10000);
    done;
    op(1'b1, 1'b0, 8'h1C, 32'h3);
    rd(8'h1C, 32'h3);
    op(1'b1, 1'b0, 8'h04, 32'h4005);
    m_rc = 3;
    m_rct = 1;
    ctl(3'h4);
    tick(6);
    rd(8'h10, m_cv);
    // line a trigger on rising edges only: the falling edge must not reset
    op(1'b1, 1'b0, 8'h04, 32'h505);
    m_rct = 0;
    set_lvl(2, 1'b0);
    tick(1);
    rd(8'h10, m_cv);
    set_lvl(2, 1'b1);
    m_pend = 1;
    tick(2);
    rd(8'h10, m_cv);
    done;
    // channel 0 counts channel 1's line a once the block mode chains it
    op(1'b1, 1'b0, 8'h44, 32'h0);
    op(1'b1, 1'b0, 8'hC4, 32'h2);
    rd(8'hC4, 32'h2);
    op(1'b1, 1'b0, 8'h04, 32'h5);
    m_src = 3;
    tick(2);
    rd(8'h10, m_cv);
    set_lvl(0, 1'b1);
    set_lvl(0, 1'b0);
    rd(8'h10, m_cv);
    idle(2);
    done;
    conclude;
  end
  initial begin
    repeat (4000) @(posedge core_clk_in);
    n_fail = n_fail + 1;
    $display("BAD %0t watchdog expired", $time);
    conclude;
  end
endmodule
